// File: sar_link.sv
/*
  Serial control and result interface of an 8-bit successive
  approximation converter with a 1, 2, 4 or 8 input multiplexer.
  Assumes: conversion clock, chip select, serial input and the shift
  order select arrive as asynchronous pins much slower than mclk; the
  comparator decision comes from analog logic settled on mclk.
*/
`timescale 1ns/100ps

module sar_link #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host link pins
  input wire logic cs_n,
  input wire logic conv_clk,
  input wire logic serial_in,
  input wire logic lsb_first_select_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic conversion_active,
  // Analog front end
  input wire logic comp_decision,
  output logic [7:0] sar_trial,
  output logic [2:0] pos_channel,
  output logic [2:0] neg_channel,
  output logic neg_common
);

  localparam int WORD_LEN = sar_link_pkg::word_len(CHANNELS);
  localparam int AL_SHIFT = sar_link_pkg::WORD_MAX - WORD_LEN;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] cs_sync_r;
  logic [1:0] clk_sync_r;
  logic [1:0] din_sync_r;
  logic [1:0] sel_sync_r;
  logic clk_last_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_sync_r <= {2{sar_link_pkg::RST_PIN_HIGH}};
      clk_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
      sel_sync_r <= {2{sar_link_pkg::RST_PIN_HIGH}};
      clk_last_r <= 1'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_n};
      clk_sync_r <= {clk_sync_r[0], conv_clk};
      din_sync_r <= {din_sync_r[0], serial_in};
      sel_sync_r <= {sel_sync_r[0], lsb_first_select_n};
      clk_last_r <= clk_sync_r[1];
    end
  end

  wire deselected = cs_sync_r[1];
  wire din_s = din_sync_r[1];
  // Only the eight input variant has the shift order pin
  wire hold_lsb = (CHANNELS == 8) && sel_sync_r[1];
  wire clk_rise = clk_sync_r[1] && !clk_last_r;
  wire clk_fall = !clk_sync_r[1] && clk_last_r;

  ////////////////////////////////////////////////////////////////////////
  // Phase decoding

  function automatic logic sampling_phase(input sar_link_pkg::phase_e p);
    sampling_phase = (p == sar_link_pkg::ST_IDLE) ||
                     (p == sar_link_pkg::ST_ADDR);
  endfunction

  sar_link_pkg::phase_e state_r;
  sar_link_pkg::phase_e state_nxt;
  logic [3:0] addr_r;
  logic [2:0] addr_cnt_r;
  logic [2:0] bit_r;
  logic [7:0] result_r;
  logic [7:0] trial_r;
  logic serial_out_r;
  logic oe_n_r;
  logic active_r;
  logic [2:0] pos_r;
  logic [2:0] neg_r;
  logic common_r;

  wire listening = sampling_phase(state_r);
  wire last_addr_bit = (addr_cnt_r == 3'(WORD_LEN - 1));

  ////////////////////////////////////////////////////////////////////////
  // Assignment word decoding

  // Left-align so the mode bit is always bit 3
  wire [3:0] addr_al = 4'(addr_r << AL_SHIFT);
  wire sgl_bit = addr_al[3];
  wire odd_bit = addr_al[2];
  wire [1:0] sel_idx = 2'(addr_al[1:0] >> AL_SHIFT);
  // Positive input is the same in both modes; pairs stay adjacent
  wire [2:0] pos_nxt = (CHANNELS == 1) ? sar_link_pkg::FIXED_POS :
                       {sel_idx, odd_bit};
  wire [2:0] neg_nxt = (CHANNELS == 1) ? sar_link_pkg::FIXED_NEG :
                       {sel_idx, ~odd_bit};
  wire common_nxt = (CHANNELS == 1) ? 1'h0 : sgl_bit;

  // Trial word for the next lower bit after this decision
  wire [7:0] decided = result_r | (8'(comp_decision) << bit_r);
  wire [7:0] trial_nxt = (bit_r == 3'h0) ? decided :
                         decided | (8'h01 << (bit_r - 3'h1));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sar_link_pkg::ST_IDLE: begin
        // Leading zeros are ignored until the first one
        if (clk_rise && din_s) begin
          state_nxt = (WORD_LEN == 0) ? sar_link_pkg::ST_SETTLE :
                      sar_link_pkg::ST_ADDR;
        end
      end
      sar_link_pkg::ST_ADDR: begin
        if (clk_rise && last_addr_bit) begin
          state_nxt = sar_link_pkg::ST_SETTLE;
        end
      end
      sar_link_pkg::ST_SETTLE: begin
        if (clk_fall) begin
          state_nxt = sar_link_pkg::ST_CONV;
        end
      end
      sar_link_pkg::ST_CONV: begin
        if (clk_fall && bit_r == 3'h0) begin
          state_nxt = (CHANNELS == 1) ? sar_link_pkg::ST_DONE :
                      sar_link_pkg::ST_LSB;
        end
      end
      sar_link_pkg::ST_LSB: begin
        if (clk_fall && !hold_lsb && bit_r == 3'h0) begin
          state_nxt = sar_link_pkg::ST_DONE;
        end
      end
      sar_link_pkg::ST_DONE: begin
        state_nxt = sar_link_pkg::ST_DONE;
      end
      default: begin
        state_nxt = sar_link_pkg::ST_IDLE;
      end
    endcase
  end

  // Deselect is the frame's own clear; nothing survives between frames
  always_ff @(posedge mclk) begin
    if (rst || deselected) begin
      state_r <= sar_link_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address shift register

  always_ff @(posedge mclk) begin
    if (rst || deselected) begin
      addr_r <= 4'h0;
      addr_cnt_r <= 3'h0;
    end else if (state_r == sar_link_pkg::ST_ADDR && clk_rise) begin
      addr_r <= {addr_r[2:0], din_s};
      addr_cnt_r <= addr_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion and result shifting

  always_ff @(posedge mclk) begin
    if (rst || deselected) begin
      bit_r <= 3'h0;
      result_r <= 8'h00;
      trial_r <= 8'h00;
      serial_out_r <= sar_link_pkg::RST_SERIAL_OUT;
      oe_n_r <= sar_link_pkg::RST_OE_N;
      pos_r <= 3'h0;
      neg_r <= 3'h0;
      common_r <= 1'h0;
    end else if (clk_fall) begin
      unique case (state_r)
        sar_link_pkg::ST_SETTLE: begin
          oe_n_r <= 1'h0;
          serial_out_r <= 1'h0;
          bit_r <= sar_link_pkg::BIT_MSB;
          trial_r <= sar_link_pkg::TRIAL_FIRST;
          pos_r <= pos_nxt;
          neg_r <= neg_nxt;
          common_r <= common_nxt;
        end
        sar_link_pkg::ST_CONV: begin
          // Reversed inputs never trip the comparator: code stays zero
          serial_out_r <= comp_decision;
          result_r <= decided;
          trial_r <= trial_nxt;
          bit_r <= (bit_r == 3'h0) ? sar_link_pkg::BIT_LSB_NEXT :
                   bit_r - 3'h1;
        end
        sar_link_pkg::ST_LSB: begin
          // Pin high freezes the LSB on the output
          if (!hold_lsb) begin
            serial_out_r <= (bit_r == 3'h0) ? 1'h0 : result_r[bit_r];
            bit_r <= bit_r + 3'h1;
          end
        end
        sar_link_pkg::ST_DONE: begin
          serial_out_r <= 1'h0;
        end
        default: begin
          serial_out_r <= serial_out_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion status

  always_ff @(posedge mclk) begin
    if (rst || deselected) begin
      active_r <= 1'h0;
    end else if (state_r == sar_link_pkg::ST_SETTLE && clk_fall) begin
      active_r <= 1'h1;
    end else if (clk_rise && !listening &&
                 state_r != sar_link_pkg::ST_SETTLE &&
                 state_r != sar_link_pkg::ST_CONV) begin
      active_r <= 1'h0;
    end
  end

  assign serial_out = serial_out_r;
  assign serial_out_oe_n = oe_n_r;
  assign conversion_active = active_r;
  assign sar_trial = trial_r;
  assign pos_channel = pos_r;
  assign neg_channel = neg_r;
  assign neg_common = common_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Decision falls seen while the status is high
  logic [3:0] act_falls_r;
  always_ff @(posedge mclk) begin
    if (rst || !active_r) begin
      act_falls_r <= 4'h0;
    end else if (clk_fall) begin
      act_falls_r <= act_falls_r + 4'h1;
    end
  end

  a_float_addressing: assert property (
    listening |-> serial_out_oe_n)
    else $error("serial output driven while addressing");

  a_settle_zero: assert property (
    $rose(conversion_active) |-> !serial_out_oe_n && !serial_out)
    else $error("no leading zero at settle");

  // Counter keeps its count on the edge where the status drops
  a_status_span: assert property (
    $fell(conversion_active) && !$past(deselected) |->
      act_falls_r == 4'h8 && $past(act_falls_r) == 4'h8)
    else $error("status span not eight periods");

  a_deselect_clear: assert property (
    deselected |=> state_r == sar_link_pkg::ST_IDLE && !conversion_active
      && serial_out_oe_n)
    else $error("deselect did not clear");

  a_msb_decision: assert property (
    state_r == sar_link_pkg::ST_CONV && clk_fall && !deselected |=>
      serial_out == $past(comp_decision))
    else $error("decision not on serial output");

  a_done_low: assert property (
    state_r == sar_link_pkg::ST_DONE && clk_fall && !deselected |=>
      !serial_out && !serial_out_oe_n)
    else $error("output not low after result");

  a_single_msb: assert property (
    CHANNELS == 1 |-> state_r != sar_link_pkg::ST_LSB)
    else $error("single input variant streamed lsb first");

  a_start_bit: assert property (
    state_r == sar_link_pkg::ST_IDLE && clk_rise && din_s && !deselected
      |=> state_r != sar_link_pkg::ST_IDLE)
    else $error("start bit missed");

  a_hold_lsb: assert property (
    state_r == sar_link_pkg::ST_LSB && hold_lsb && !deselected
      |=> $stable(serial_out))
    else $error("lsb not held");

  a_pair_adjacent: assert property (
    $rose(conversion_active) && !neg_common && CHANNELS > 1 |->
      neg_channel == (pos_channel ^ 3'h1))
    else $error("differential pair not adjacent");

  c_full_conv: cover property (
    $fell(conversion_active) && !deselected);
  c_lsb_stream: cover property (
    state_r == sar_link_pkg::ST_LSB ##1 state_r == sar_link_pkg::ST_DONE);
  c_diff_mode: cover property ($rose(conversion_active) && !neg_common);
  c_lsb_hold: cover property (
    state_r == sar_link_pkg::ST_LSB && hold_lsb ##1 clk_fall);
  c_single_mode: cover property ($rose(conversion_active) && neg_common);

endmodule

// File: sar_link_pkg.sv
/*
  Shared constants, state encoding and variant decoding for the serial
  converter control block.
  Assumes a single system clock domain; all pins are sampled by the block.
*/
package sar_link_pkg;

  // Result and address word sizes, synchroniser depth
  localparam int RESULT_BITS = 8;
  localparam int WORD_MAX = 4;
  localparam int SYNC_STAGES = 2;

  // Reset values of the pin-facing flops, then start values of the conversion and LSB stream
  localparam logic RST_SERIAL_OUT = 1'h0;
  localparam logic RST_OE_N = 1'h1;
  localparam logic RST_PIN_HIGH = 1'h1;
  localparam logic [7:0] TRIAL_FIRST = 8'h80;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB_NEXT = 3'h1;

  // Fixed input pair of the single-input variant
  localparam logic [2:0] FIXED_POS = 3'h0;
  localparam logic [2:0] FIXED_NEG = 3'h1;

  // Gray codes along idle, address, settle, convert, lsb stream, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_SETTLE = 3'h3,
    ST_CONV = 3'h2,
    ST_LSB = 3'h6,
    ST_DONE = 3'h7
  } phase_e;

  // Assignment word length for each multiplexer size
  function automatic int word_len(input int channels);
    case (channels)
      1: word_len = 0;
      2: word_len = 2;
      4: word_len = 3;
      default: word_len = 4;
    endcase
  endfunction

endpackage

// File: host_link.sv
/*
  Host side of the serial converter link: frames, link clock, data pin.
  Assumes the bench calls its tasks just after an mclk rising edge.
*/
`timescale 1ns/100ps

module host_link (
  // System clock
  input wire logic mclk,
  // Link pins driven by the host
  output logic cs_n,
  output logic conv_clk,
  output logic serial_in,
  output logic lsb_first_select_n
);
  // Six mclk per link phase keeps each phase above the sync floor
  localparam int PHASE = 6;

  initial begin
    cs_n = 1'h1;
    conv_clk = 1'h0;
    serial_in = 1'h0;
    lsb_first_select_n = 1'h1;
  end

  task automatic half();
    repeat (PHASE) @(posedge mclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Select, start bit, word, then clock out the whole result
  task automatic frame(input logic [3:0] word, input int lead,
                       input logic hold);
    lsb_first_select_n = hold;
    half();
    cs_n = 1'h0;
    for (int i = 0; i < lead + 23; i++) begin
      if (i < lead)
        serial_in = 1'h0;
      else if (i == lead)
        serial_in = 1'h1;
      else if (i <= lead + 4)
        serial_in = word[lead + 4 - i];
      else
        serial_in = ~serial_in;
      half();
      conv_clk = 1'h1;
      half();
      conv_clk = 1'h0;
    end
  endtask

  // Clock stays low between frames
  task automatic release_cs();
    half();
    cs_n = 1'h1;
    half();
  endtask
endmodule

// File: tb_top.sv
/*
  Self-checking bench for the converter link, eight input variant.
  Assumes the host model paces the link and a comparator model of vin.
*/
`timescale 1ns/100ps

module tb_top;
  logic mclk;
  logic rst;
  logic cs_n;
  logic conv_clk;
  logic serial_in;
  logic lsb_first_select_n;
  logic serial_out;
  logic serial_out_oe_n;
  logic conversion_active;
  logic comp_decision;
  logic [7:0] sar_trial;
  logic [2:0] pos_channel;
  logic [2:0] neg_channel;
  logic neg_common;
  logic [7:0] vin;
  logic [31:0] lfsr;
  logic [2:0] exp_q[$];
  int mismatches;
  int samples_checked;
  int cycles;

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // Ideal comparator: keep a trial bit while the input is not below it
  assign comp_decision = (vin >= sar_trial);

  sar_link #(.CHANNELS(8)) dut_u (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .conv_clk(conv_clk), .serial_in(serial_in),
    .lsb_first_select_n(lsb_first_select_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .conversion_active(conversion_active),
    .comp_decision(comp_decision), .sar_trial(sar_trial),
    .pos_channel(pos_channel), .neg_channel(neg_channel),
    .neg_common(neg_common));

  host_link host_u (.mclk(mclk), .cs_n(cs_n), .conv_clk(conv_clk),
    .serial_in(serial_in), .lsb_first_select_n(lsb_first_select_n));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report(input string what, input logic [2:0] e,
                        input logic [2:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_link(input logic [2:0] e, input logic [2:0] g);
    report("oe_n/active/out", e, g);
  endtask

  task automatic check_sel(input string what, input logic [2:0] e,
                           input logic [2:0] g);
    report(what, e, g);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One note per link rise: floating address, zero, MSB..LSB, tail
  task automatic expect_frame(input int lead, input logic hold);
    for (int i = 0; i < lead + 5; i++)
      exp_q.push_back(3'h4);
    exp_q.push_back(3'h2);
    for (int k = 1; k <= 8; k++)
      exp_q.push_back({2'h1, vin[8 - k]});
    for (int k = 1; k <= 7; k++)
      exp_q.push_back({2'h0, hold ? vin[0] : vin[k]});
    // Held order keeps the LSB instead of dropping low
    exp_q.push_back({2'h0, hold & vin[0]});
    exp_q.push_back({2'h0, hold & vin[0]});
  endtask

  // Float masks the data bit, since nothing is driven then
  always @(posedge conv_clk) begin
    if (cs_n === 1'h0 && exp_q.size() > 0) begin
      logic [2:0] e;
      e = exp_q.pop_front();
      check_link(e, {serial_out_oe_n, conversion_active,
        e[2] ? e[0] : serial_out});
    end
  end

  task automatic run(input logic [3:0] w, input int lead, input logic hold);
    expect_frame(lead, hold);
    host_u.frame(w, lead, hold);
    check_sel("pos", {w[1:0], w[2]}, pos_channel);
    check_sel("common", {2'h0, w[3]}, {2'h0, neg_common});
    if (!w[3])
      check_sel("neg", {w[1:0], ~w[2]}, neg_channel);
    check_sel("left", 3'h0, exp_q.size() > 0 ? 3'h7 : 3'h0);
    host_u.release_cs();
    check_sel("cleared", 3'h4, {serial_out_oe_n, conversion_active,
      1'h0});
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'h1;
    vin = 8'h00;
    lfsr = 32'hada3;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'h0;
    repeat (4) @(posedge mclk);
    #1;
    // Every mode and channel code, mode flipped on each conversion except from the eighth to the ninth
    for (int m = 0; m < 16; m++) begin
      lfsr = lfsr_next(lfsr);
      vin = (m == 3) ? 8'h00 : (m == 12) ? 8'hff : lfsr[7:0];
      run(m[3:0] ^ {m[0], 3'h0}, m % 3, lfsr[9]);
    end
    print_verdict();
  end
endmodule
